// ==== common/term_pkg.sv ====
// constants for the terminal speed and run-command logic
// assumes one 250 MHz control clock; function codes are the drive's terminal codes
package term_pkg;
	localparam int          FUNC_W          = 6;
	localparam logic [5:0]  FN_JOG          = 6'h06;
	localparam logic [5:0]  FN_RUN_PERMIT   = 6'h0D;
	localparam logic [5:0]  FN_THREE_WIRE   = 6'h0E;
	localparam logic [5:0]  FN_SPEED_RAISE  = 6'h11;
	localparam logic [5:0]  FN_SPEED_LOWER  = 6'h12;
	localparam logic [5:0]  FN_UD_CLEAR     = 6'h14;
	localparam logic [2:0]  CMD_SRC_TERMINAL = 3'h1;
	localparam logic [1:0]  ACT_FREE_RUN    = 2'h0;
	localparam logic [1:0]  ACT_QSTOP       = 2'h1;
	localparam logic [1:0]  ACT_QSTOP_RESUME = 2'h2;
	// quick-stop time in 0.1 s steps: 0..600 s, default 5.0 s
	localparam logic [15:0] QSTOP_MAX       = 16'h1770;
	localparam logic [15:0] QSTOP_DEFAULT   = 16'h0032;
	localparam int          CLK_MHZ         = 250;
	localparam int          MIN_PULSE_US    = 1000;
	localparam int          MIN_PULSE_CYC   = MIN_PULSE_US * CLK_MHZ;
	typedef enum logic [1:0] {PS_OK, PS_COAST, PS_QSTOP, PS_LOCK} permit_state_t;
endpackage

// ==== design/pulse_qualifier.sv ====
// per-bit stability filter: an output bit follows its input once stable for CYC cycles
// assumes inputs synchronous to sys_clk_i
`timescale 1ns/100ps
`default_nettype none
module pulse_qualifier #(
	parameter int WIDTH = 3,
	parameter int CYC   = term_pkg::MIN_PULSE_CYC
)(
	// clock and reset
	input  wire logic             sys_clk_i,
	input  wire logic             rstn_i,
	// levels
	input  wire logic [WIDTH-1:0] level_i,
	output logic      [WIDTH-1:0] level_o
);
	localparam int CW = $clog2(CYC + 1);
	localparam logic [CW-1:0] LAST = CW'(CYC - 1);
	logic [CW-1:0]    cnt_q [WIDTH];
	wire  [WIDTH-1:0] differ;
	wire  [WIDTH-1:0] done;

	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		assign differ[i] = level_i[i] != level_o[i];
		assign done[i]   = differ[i] && (cnt_q[i] == LAST);
		stable_accept_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
			(level_o[i] != $past(level_o[i])) |-> $past(cnt_q[i]) == LAST)
			else $error("qualified level changed before hold time");
	end

	// one process owns every bit, so no variable has two writers
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			for (int i = 0; i < WIDTH; i++) begin
				cnt_q[i] <= '0;
			end
			level_o <= '0;
		end else begin
			for (int i = 0; i < WIDTH; i++) begin
				cnt_q[i] <= (differ[i] && !done[i]) ? cnt_q[i] + 1'b1 : '0;
			end
			level_o <= (level_o & ~done) | (level_i & done);
		end
	end
endmodule
`default_nettype wire

// ==== design/terminal_speed_run_logic.sv ====
// terminal command logic: up/down speed, three-wire latching, run permit
// assumes a ramp generator downstream and a nonvolatile store that takes one-cycle strobes
`timescale 1ns/100ps
`default_nettype none

// How it works
// - with retention on, save frequency at steady speed on run-off, trip or power loss.
// - on run restart or trip clearing, resume at the retained frequency.
// - clear input erases retained frequency when stopped or at steady speed.
// - function codes 17 and 18 pick the raise and lower inputs.
// - raise held while running accelerates; release holds the speed.
// - lower held while running decelerates; release holds the speed.
// - raise and lower together hold the present speed.
// - terminal command source plus code 14 latches momentary run pulses.
// - forward and reverse together stop the motor.
// - a terminal assigned code 13 is the run-permit input.
// - a permit input alone does nothing without the gated permit setting.
// - gated setting obeys permit input; ungated setting always permits running.
// - permit loss action 0 blocks output at once, motor coasts.
// - action 1 quick-stops and restarts only on a fresh run command.
// - action 2 quick-stops and resumes by itself when permit returns.
// - quick-stop time 0 to 600 s, default 5.0 s, for actions 1 and 2.
// - jog input overrides up/down; it needs a run command and leaves three-wire latching as is.
module terminal_speed_run_logic #(
	parameter int N_INPUTS = 11,
	parameter int FREQ_W   = 16,
	parameter int QUAL_CYC = term_pkg::MIN_PULSE_CYC
)(
	// clock and reset
	input  wire logic                                  sys_clk_i,
	input  wire logic                                  rstn_i,
	// terminals
	input  wire logic                                  forward_run_input_i,
	input  wire logic                                  reverse_run_input_i,
	input  wire logic [N_INPUTS-1:0]                   multi_function_input_i,
	// configuration
	input  wire logic [N_INPUTS*term_pkg::FUNC_W-1:0]  input_function_select_i,
	input  wire logic [2:0]                            cmd_source_i,
	input  wire logic                                  ud_save_en_i,
	input  wire logic                                  input_gated_permit_i,
	input  wire logic [1:0]                            permit_loss_action_i,
	input  wire logic [15:0]                           quick_stop_time_i,
	// drive status
	input  wire logic                                  at_speed_i,
	input  wire logic [FREQ_W-1:0]                     present_freq_i,
	input  wire logic                                  trip_i,
	input  wire logic                                  power_fail_i,
	// nonvolatile contents seen at power-up
	input  wire logic [FREQ_W-1:0]                     nv_freq_i,
	input  wire logic                                  nv_valid_i,
	// run control
	output logic                                       run_o,
	output logic                                       reverse_o,
	output logic                                       coast_o,
	output logic                                       quick_stop_o,
	output logic [15:0]                                quick_stop_time_o,
	// speed control
	output logic                                       accel_o,
	output logic                                       decel_o,
	output logic                                       jog_o,
	output logic                                       resume_o,
	output logic [FREQ_W-1:0]                          resume_freq_o,
	// nonvolatile store
	output logic                                       nv_store_o,
	output logic                                       nv_erase_o,
	output logic [FREQ_W-1:0]                          nv_freq_o
);
	localparam int FW = term_pkg::FUNC_W;

	function automatic logic any_func(
		input logic [N_INPUTS*FW-1:0] sel,
		input logic [N_INPUTS-1:0]    pins,
		input logic [FW-1:0]          code
	);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < N_INPUTS; i++) begin
			hit = hit | (pins[i] && (sel[i*FW +: FW] == code));
		end
		return hit;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// terminal decode

	wire fn_jog    = any_func(input_function_select_i, multi_function_input_i,
		term_pkg::FN_JOG);
	wire fn_permit = any_func(input_function_select_i, multi_function_input_i,
		term_pkg::FN_RUN_PERMIT);
	wire fn_3w     = any_func(input_function_select_i, multi_function_input_i,
		term_pkg::FN_THREE_WIRE);
	wire fn_up     = any_func(input_function_select_i, multi_function_input_i,
		term_pkg::FN_SPEED_RAISE);
	wire fn_down   = any_func(input_function_select_i, multi_function_input_i,
		term_pkg::FN_SPEED_LOWER);
	wire fn_clear  = any_func(input_function_select_i, multi_function_input_i,
		term_pkg::FN_UD_CLEAR);

	////////////////////////////////////////////////////////////////////////////
	// three-wire latching

	// mode follows the code-14 assignment, not the contact: an open stop still stops
	wire fn_3w_set  = any_func(input_function_select_i, {N_INPUTS{1'b1}},
		term_pkg::FN_THREE_WIRE);
	wire three_wire = (cmd_source_i == term_pkg::CMD_SRC_TERMINAL) && fn_3w_set;

	logic [2:0] qual;
	// filtering adds 1 ms latency to button edges; bounces shorter are ignored
	pulse_qualifier #(
		.WIDTH (3),
		.CYC   (QUAL_CYC)
	) u_qual (
		.sys_clk_i (sys_clk_i),
		.rstn_i    (rstn_i),
		.level_i   ({fn_3w, reverse_run_input_i, forward_run_input_i}),
		.level_o   (qual)
	);

	wire fwd_sel  = three_wire ? qual[0] : forward_run_input_i;
	wire rev_sel  = three_wire ? qual[1] : reverse_run_input_i;
	wire both_on  = fwd_sel && rev_sel;
	wire stop_ok  = three_wire && qual[2];

	logic lat_fwd_q;
	logic lat_rev_q;
	wire  lat_fwd_d = stop_ok && !both_on && (fwd_sel || (lat_fwd_q && !rev_sel));
	wire  lat_rev_d = stop_ok && !both_on && (rev_sel || (lat_rev_q && !fwd_sel));

	// both directions on also masks a latch still set from the cycle before
	wire cmd_fwd = !both_on && (three_wire ? lat_fwd_q : fwd_sel);
	wire cmd_rev = !both_on && (three_wire ? lat_rev_q : rev_sel);
	wire cmd_on  = cmd_fwd || cmd_rev;

	////////////////////////////////////////////////////////////////////////////
	// run permit

	// the permit terminal counts only when the gated setting is chosen
	wire permit_ok = !input_gated_permit_i || fn_permit;

	term_pkg::permit_state_t ps_q;
	term_pkg::permit_state_t ps_d;

	always_comb begin
		ps_d = ps_q;
		case (ps_q)
			term_pkg::PS_OK: begin
				if (!permit_ok) begin
					case (permit_loss_action_i)
						term_pkg::ACT_QSTOP:        ps_d = term_pkg::PS_LOCK;
						term_pkg::ACT_QSTOP_RESUME: ps_d = term_pkg::PS_QSTOP;
						default:                    ps_d = term_pkg::PS_COAST;
					endcase
				end
			end
			term_pkg::PS_COAST: begin
				if (permit_ok) ps_d = term_pkg::PS_OK;
			end
			term_pkg::PS_QSTOP: begin
				if (permit_ok) ps_d = term_pkg::PS_OK;
			end
			term_pkg::PS_LOCK: begin
				// leave only once the command is off, so a fresh one is needed
				if (permit_ok && !cmd_on) ps_d = term_pkg::PS_OK;
			end
			default: ps_d = term_pkg::PS_OK;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// speed commands

	wire run_d   = cmd_on && (ps_d == term_pkg::PS_OK);
	wire coast_d = ps_d == term_pkg::PS_COAST;
	wire qstop_d = (ps_d == term_pkg::PS_QSTOP) || (ps_d == term_pkg::PS_LOCK);
	wire jog_d   = run_d && fn_jog;
	wire accel_d = run_d && !fn_jog && fn_up && !fn_down;
	wire decel_d = run_d && !fn_jog && fn_down && !fn_up;
	wire [15:0] qs_time_d = (quick_stop_time_i > term_pkg::QSTOP_MAX) ?
		term_pkg::QSTOP_MAX : quick_stop_time_i;

	////////////////////////////////////////////////////////////////////////////
	// frequency retention

	logic              trip_q;
	logic              pf_q;
	logic              boot_q;
	logic              ret_valid_q;
	logic [FREQ_W-1:0] ret_freq_q;

	wire steady    = run_o && at_speed_i;
	wire store_ev  = ud_save_en_i && steady &&
		(!run_d || (trip_i && !trip_q) || (power_fail_i && !pf_q));
	wire clear_ev  = fn_clear && (!run_o || at_speed_i);
	wire resume_ev = ud_save_en_i && ret_valid_q &&
		((run_d && !run_o) || (!trip_i && trip_q));
	// a save in the same cycle as a clear wins
	wire ret_valid_d = store_ev ? 1'b1 : (clear_ev ? 1'b0 :
		(boot_q ? nv_valid_i : ret_valid_q));
	wire [FREQ_W-1:0] ret_freq_d = store_ev ? present_freq_i :
		(boot_q ? nv_freq_i : ret_freq_q);

	////////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ps_q        <= term_pkg::PS_OK;
			lat_fwd_q   <= 1'b0;
			lat_rev_q   <= 1'b0;
			trip_q      <= 1'b0;
			pf_q        <= 1'b0;
			boot_q      <= 1'b1;
			ret_valid_q <= 1'b0;
			ret_freq_q  <= '0;
		end else begin
			ps_q        <= ps_d;
			lat_fwd_q   <= lat_fwd_d;
			lat_rev_q   <= lat_rev_d;
			trip_q      <= trip_i;
			pf_q        <= power_fail_i;
			boot_q      <= 1'b0;
			ret_valid_q <= ret_valid_d;
			ret_freq_q  <= ret_freq_d;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			run_o             <= 1'b0;
			reverse_o         <= 1'b0;
			coast_o           <= 1'b0;
			quick_stop_o      <= 1'b0;
			quick_stop_time_o <= term_pkg::QSTOP_DEFAULT;
			accel_o           <= 1'b0;
			decel_o           <= 1'b0;
			jog_o             <= 1'b0;
		end else begin
			run_o             <= run_d;
			reverse_o         <= cmd_rev;
			coast_o           <= coast_d;
			quick_stop_o      <= qstop_d;
			quick_stop_time_o <= qs_time_d;
			accel_o           <= accel_d;
			decel_o           <= decel_d;
			jog_o             <= jog_d;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			resume_o      <= 1'b0;
			resume_freq_o <= '0;
			nv_store_o    <= 1'b0;
			nv_erase_o    <= 1'b0;
			nv_freq_o     <= '0;
		end else begin
			resume_o      <= resume_ev;
			resume_freq_o <= ret_freq_q;
			nv_store_o    <= store_ev;
			nv_erase_o    <= clear_ev && !store_ev;
			nv_freq_o     <= store_ev ? present_freq_i : nv_freq_o;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rstn_i);

	both_dir_stop_a: assert property (both_on |=> !run_o)
		else $error("run kept with both directions on");
	raise_accel_a: assert property (run_d && !fn_jog && fn_up && !fn_down |=> accel_o)
		else $error("raise did not accelerate");
	lower_decel_a: assert property (run_d && !fn_jog && fn_down && !fn_up |=> decel_o)
		else $error("lower did not decelerate");
	updown_hold_a: assert property (fn_up && fn_down |=> !accel_o && !decel_o)
		else $error("speed changed with raise and lower both on");
	jog_override_a: assert property (run_d && fn_jog |=> jog_o && !accel_o && !decel_o)
		else $error("jog did not override");
	free_run_a: assert property (ps_q == term_pkg::PS_OK && !permit_ok &&
		permit_loss_action_i == term_pkg::ACT_FREE_RUN |=> coast_o && !run_o)
		else $error("permit loss did not block output");
	lock_restart_a: assert property (ps_q == term_pkg::PS_LOCK && cmd_on
		|=> !run_o && quick_stop_o)
		else $error("restart without fresh command");
	auto_resume_a: assert property (ps_q == term_pkg::PS_QSTOP && permit_ok && cmd_on
		|=> run_o)
		else $error("no automatic resume");
	ungated_run_a: assert property (!input_gated_permit_i && cmd_on &&
		ps_q == term_pkg::PS_OK |=> run_o ##1 (run_o || !$past(cmd_on)))
		else $error("ungated run refused");
	freq_store_a: assert property (store_ev |=> nv_store_o &&
		nv_freq_o == $past(present_freq_i) && ret_valid_q)
		else $error("retained frequency not stored");
	freq_erase_a: assert property (clear_ev && !store_ev |=> nv_erase_o && !ret_valid_q)
		else $error("retained frequency not erased");
	freq_resume_a: assert property (resume_ev |=> resume_o &&
		resume_freq_o == $past(ret_freq_q))
		else $error("resume lost retained frequency");
	stop_clear_a: assert property (three_wire && !qual[2] |=> !lat_fwd_q && !lat_rev_q)
		else $error("latch survived stop input");
	qstop_range_a: assert property (quick_stop_time_o <= term_pkg::QSTOP_MAX)
		else $error("quick-stop time out of range");

	latched_run_c: cover property (three_wire && !fwd_sel ##1 run_o && lat_fwd_q);
	lock_path_c:   cover property (ps_q == term_pkg::PS_LOCK ##[1:20] run_o);
	store_path_c:  cover property (nv_store_o ##[1:20] resume_o);
endmodule
`default_nettype wire

// ==== verif/terminal_switches.sv ====
// switch and limit-contact model for the drive's terminal inputs
// assumes the bench calls its tasks; contacts move on the falling edge
`timescale 1ns/100ps
`default_nettype none
module terminal_switches #(
	parameter int N = 11
)(
	input  wire logic         sys_clk_i,
	output logic              fwd_o,
	output logic              rev_o,
	output logic [N-1:0]      mfi_o
);
	////////////////////////////////////////////////////////////
	initial begin
		fwd_o = 1'h0;
		rev_o = 1'h0;
		mfi_o = '0;
	end

	// pin -1 forward, -2 reverse, else a multi-function contact
	task automatic set_pin(input int pin, input logic v);
		@(negedge sys_clk_i);
		if (pin == -1) begin
			fwd_o = v;
		end else if (pin == -2) begin
			rev_o = v;
		end else begin
			mfi_o[pin] = v;
		end
	endtask

	// push button: held cyc+1 cycles, short ones exist only to be refused
	task automatic press(input int pin, input int cyc);
		set_pin(pin, 1'h1);
		repeat (cyc) @(negedge sys_clk_i);
		set_pin(pin, 1'h0);
	endtask
endmodule
`default_nettype wire

// ==== verif/tb_terminal_speed_run_logic.sv ====
// self-checking bench for the terminal speed and run-command logic
// assumes the switch model on the terminals and a 250 MHz clock
`timescale 1ns/100ps
`default_nettype none
module tb_terminal_speed_run_logic;
	localparam int NI = 11;
	localparam int QC = 4;
	logic                          sys_clk_i;
	logic                          rstn_i;
	logic                          fwd, rev, run, reverse, coast, qstop;
	logic                          accel, decel, jog, resume, store, erase;
	logic                          save_en, gated, at_speed, trip, pfail, nv_valid;
	logic [NI-1:0]                 mfi;
	logic [NI*term_pkg::FUNC_W-1:0] fsel;
	logic [2:0]                    cmd_src;
	logic [1:0]                    act;
	logic [15:0]                   qtime, freq, nv_freq, qtime_o, res_freq, st_freq;
	int                            errors, check_count, cyc;
	int                            acts [4] = '{0, 2, 3, 1};

	terminal_switches #(.N(NI)) sw_u (.sys_clk_i(sys_clk_i), .fwd_o(fwd), .rev_o(rev),
		.mfi_o(mfi));
	terminal_speed_run_logic #(.N_INPUTS(NI), .FREQ_W(16), .QUAL_CYC(QC)) dut_u (
		.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .forward_run_input_i(fwd),
		.reverse_run_input_i(rev), .multi_function_input_i(mfi),
		.input_function_select_i(fsel), .cmd_source_i(cmd_src), .ud_save_en_i(save_en),
		.input_gated_permit_i(gated), .permit_loss_action_i(act),
		.quick_stop_time_i(qtime), .at_speed_i(at_speed), .present_freq_i(freq),
		.trip_i(trip), .power_fail_i(pfail), .nv_freq_i(nv_freq), .nv_valid_i(nv_valid),
		.run_o(run), .reverse_o(reverse), .coast_o(coast), .quick_stop_o(qstop),
		.quick_stop_time_o(qtime_o), .accel_o(accel), .decel_o(decel), .jog_o(jog),
		.resume_o(resume), .resume_freq_o(res_freq), .nv_store_o(store),
		.nv_erase_o(erase), .nv_freq_o(st_freq));

	////////////////////////////////////////////////////////////
	initial begin
		sys_clk_i = 1'h0;
		forever #2 sys_clk_i = ~sys_clk_i;
	end

	// generous ceiling: the whole run is under two hundred cycles
	always @(posedge sys_clk_i) begin
		cyc++;
		if (cyc == 5000) begin
			errors++;
			test_done();
		end
	end

	task automatic tick(input int n);
		repeat (n) @(negedge sys_clk_i);
	endtask

	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic test_done();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////
	initial begin
		rstn_i = 1'h0;
		fsel = '0;
		fsel[0+:6] = term_pkg::FN_SPEED_RAISE;
		fsel[6+:6] = term_pkg::FN_SPEED_LOWER;
		fsel[12+:6] = term_pkg::FN_UD_CLEAR;
		fsel[18+:6] = term_pkg::FN_RUN_PERMIT;
		fsel[30+:6] = term_pkg::FN_JOG;
		cmd_src = 3'h1;
		{save_en, gated, at_speed, trip, pfail, nv_valid} = 6'h00;
		act = 2'h0;
		qtime = 16'h0032;
		freq = 16'h1234;
		nv_freq = 16'h0000;
		tick(16);
		chk("qstop_time", 16'h0032, qtime_o);
		rstn_i = 1'h1;
		tick(2);
		// levels: permit pin low but gating off
		sw_u.set_pin(-1, 1'h1);
		tick(1);
		chk("run", 16'h1, run);
		sw_u.set_pin(0, 1'h1);
		tick(1);
		chk("accel", 16'h1, accel);
		sw_u.set_pin(0, 1'h0);
		tick(1);
		chk("accel", 16'h0, accel);
		sw_u.set_pin(1, 1'h1);
		tick(1);
		chk("decel", 16'h1, decel);
		sw_u.set_pin(0, 1'h1);
		tick(1);
		chk("acc_dec", 16'h0, {accel, decel});
		sw_u.set_pin(5, 1'h1);
		tick(1);
		chk("jog", 16'h1, jog);
		sw_u.set_pin(0, 1'h0);
		sw_u.set_pin(1, 1'h0);
		sw_u.set_pin(5, 1'h0);
		sw_u.set_pin(-2, 1'h1);
		tick(1);
		chk("run", 16'h0, run);
		sw_u.set_pin(-2, 1'h0);
		// retention
		save_en = 1'h1;
		at_speed = 1'h1;
		sw_u.set_pin(-1, 1'h0);
		tick(1);
		chk("store", 16'h1, store);
		chk("store_freq", 16'h1234, st_freq);
		tick(1);
		chk("store", 16'h0, store);
		sw_u.set_pin(-1, 1'h1);
		tick(1);
		chk("resume", 16'h1, resume);
		chk("resume_freq", 16'h1234, res_freq);
		freq = 16'h0ABC;
		trip = 1'h1;
		tick(1);
		chk("store_freq", 16'h0ABC, st_freq);
		trip = 1'h0;
		tick(1);
		chk("resume", 16'h1, resume);
		freq = 16'h0567;
		pfail = 1'h1;
		tick(1);
		chk("store", 16'h1, store);
		chk("store_freq", 16'h0567, st_freq);
		pfail = 1'h0;
		sw_u.set_pin(-1, 1'h0);
		tick(2);
		sw_u.set_pin(2, 1'h1);
		tick(1);
		chk("erase", 16'h1, erase);
		sw_u.set_pin(2, 1'h0);
		sw_u.set_pin(-1, 1'h1);
		tick(1);
		chk("resume", 16'h0, resume);
		save_en = 1'h0;
		// permit actions, lock-out case last
		sw_u.set_pin(3, 1'h1);
		gated = 1'h1;
		tick(1);
		chk("run", 16'h1, run);
		foreach (acts[i]) begin
			act = acts[i][1:0];
			sw_u.set_pin(3, 1'h0);
			tick(1);
			chk("run", 16'h0, run);
			chk("coast", 16'(act == 2'h0 || act == 2'h3), coast);
			chk("qstop", 16'(act == 2'h1 || act == 2'h2), qstop);
			sw_u.set_pin(3, 1'h1);
			tick(1);
			chk("run", 16'(act != 2'h1), run);
			if (act == 2'h1) begin
				sw_u.set_pin(-1, 1'h0);
				sw_u.set_pin(-1, 1'h1);
				tick(1);
				chk("run", 16'h1, run);
			end
		end
		qtime = 16'h1771;
		tick(1);
		chk("qstop_time", 16'h1770, qtime_o);
		gated = 1'h0;
		// three-wire latching behind the filter
		sw_u.set_pin(-1, 1'h0);
		sw_u.set_pin(4, 1'h1);
		fsel[24+:6] = term_pkg::FN_THREE_WIRE;
		tick(QC + 4);
		chk("run", 16'h0, run);
		sw_u.press(-1, 1);
		tick(QC + 4);
		chk("run", 16'h0, run);
		sw_u.press(-1, 6);
		tick(QC + 4);
		chk("run", 16'h1, run);
		chk("reverse", 16'h0, reverse);
		// both held: stop; releasing forward first leaves reverse latched
		sw_u.set_pin(-2, 1'h1);
		sw_u.set_pin(-1, 1'h1);
		tick(QC + 4);
		chk("run", 16'h0, run);
		sw_u.set_pin(-1, 1'h0);
		sw_u.set_pin(-2, 1'h0);
		tick(QC + 4);
		chk("run", 16'h1, run);
		chk("reverse", 16'h1, reverse);
		sw_u.set_pin(4, 1'h0);
		tick(QC + 4);
		chk("run", 16'h0, run);
		// stop contact open: a forward press must not latch
		sw_u.press(-1, 6);
		tick(QC + 4);
		chk("run", 16'h0, run);
		// second reset: retained frequency comes from the store at start-up
		rstn_i = 1'h0;
		cmd_src = 3'h0;
		{save_en, nv_valid} = 2'h3;
		nv_freq = 16'h0456;
		tick(16);
		rstn_i = 1'h1;
		tick(2);
		sw_u.set_pin(-1, 1'h1);
		tick(1);
		chk("resume", 16'h1, resume);
		chk("resume_freq", 16'h0456, res_freq);
		test_done();
	end
endmodule
`default_nettype wire
